// ==== design/asx_alu.sv ====
// Purpose: Executes five instructions of an 8-bit core: two subtracts, two xors, nybble swap
// Assumes: Decoder presents one instruction per enabled cycle with file data already read
// Notes: Accumulator and flags are held here; file writes leave as a strobe that lasts one enabled cycle
`timescale 1ns/100ps
`include "asx_params.svh"
module asx_alu #(
  parameter int DATA_W = `ASX_DATA_W
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic instr_valid,
  input wire asx_pkg::asx_instr_t instr,
  input wire logic [DATA_W-1:0] file_rdata,
  output asx_pkg::asx_fwrite_t file_wr,
  output logic [DATA_W-1:0] acc,
  output asx_pkg::asx_flags_t flags
);
  import asx_pkg::*;

  // ----------------------------------------
  // Operand selection and results
  // ----------------------------------------
  wire logic go;
  wire logic is_sub;
  wire logic is_xor;
  wire logic is_swap;
  wire logic use_file;
  wire logic [DATA_W-1:0] opnd;
  wire logic [DATA_W:0] sub_full;
  wire logic [`ASX_NYB_W:0] sub_low;
  wire logic [DATA_W-1:0] result;
  wire logic to_file;

  assign go = ce && instr_valid;
  assign is_sub = instr.op == ASX_OP_SUBTRACT_ACC_FROM_LITERAL
               || instr.op == ASX_OP_SUBTRACT_ACC_FROM_FILE;
  assign is_xor = instr.op == ASX_OP_XOR_LITERAL_INTO_ACC
               || instr.op == ASX_OP_XOR_ACC_WITH_FILE;
  assign is_swap = instr.op == ASX_OP_SWAP_FILE_NYBBLES;
  assign use_file = instr.op == ASX_OP_SUBTRACT_ACC_FROM_FILE
                 || instr.op == ASX_OP_XOR_ACC_WITH_FILE || is_swap;
  assign opnd = use_file ? file_rdata : instr.literal;
  // Subtract by adding the two's complement; the extra bit is the no-borrow carry
  assign sub_full = {1'b0, opnd} + {1'b0, ~acc} + {{DATA_W{1'b0}}, 1'b1};
  assign sub_low = {1'b0, opnd[`ASX_NYB_W-1:0]} + {1'b0, ~acc[`ASX_NYB_W-1:0]}
                 + {{`ASX_NYB_W{1'b0}}, 1'b1};
  assign result = is_swap ? {opnd[`ASX_NYB_W-1:0], opnd[DATA_W-1:`ASX_NYB_W]}
                : is_xor ? (acc ^ opnd)
                : sub_full[DATA_W-1:0];
  // Literal forms ignore the destination bit and always land in the accumulator
  assign to_file = use_file && instr.dest == `ASX_DEST_FILE;

  // ----------------------------------------
  // Reference values for the checks
  // ----------------------------------------
  // Built a different way from the datapath above, so a slip in the adder or
  // the result mux shows up as a disagreement instead of agreeing with itself
  wire logic [DATA_W-1:0] ref_swap;
  wire logic [DATA_W-1:0] ref_sub;
  wire logic [DATA_W-1:0] ref_xor;
  wire logic ref_no_borrow;
  wire logic ref_no_dborrow;
  wire logic [DATA_W-1:0] dest_now;

  for (genvar b = 0; b < DATA_W; b++)
  begin : g_swap_ref
    assign ref_swap[b] = file_rdata[(b + `ASX_NYB_W) % DATA_W];
  end
  assign ref_sub = opnd - acc;
  assign ref_xor = opnd ^ acc;
  assign ref_no_borrow = opnd >= acc;
  assign ref_no_dborrow = opnd[`ASX_NYB_W-1:0] >= acc[`ASX_NYB_W-1:0];
  // Where the last result landed: the write strobe tells file from accumulator
  assign dest_now = file_wr.we ? file_wr.data : acc;

  // ----------------------------------------
  // Idle run tracking
  // ----------------------------------------
  // A saturating count keeps the property short however long the core stalls
  logic [3:0] idle_run_q;
  logic [DATA_W-1:0] acc_hold_q;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      idle_run_q <= 4'h0;
      acc_hold_q <= `ASX_ACC_RST;
    end
    else if (ce)
    begin
      if (go)
        idle_run_q <= 4'h0;
      else if (idle_run_q != 4'hf)
        idle_run_q <= idle_run_q + 4'h1;
      acc_hold_q <= acc;
    end
  end

  // ----------------------------------------
  // State update
  // ----------------------------------------
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      acc <= `ASX_ACC_RST;
      flags <= `ASX_FLAG_RST;
      file_wr <= '0;
    end
    else if (ce)
    begin
      file_wr.we <= go && to_file;
      file_wr.addr <= instr.addr;
      file_wr.data <= result;
      if (go && (is_sub || is_xor || is_swap) && !to_file)
        acc <= result;
      if (go && is_sub)
      begin
        flags.carry <= sub_full[DATA_W];
        flags.digit_carry <= sub_low[`ASX_NYB_W];
      end
      if (go && (is_sub || is_xor))
        flags.zero <= result == '0;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_sublit_acc: assert property (go && instr.op == ASX_OP_SUBTRACT_ACC_FROM_LITERAL |=>
    acc == $past(instr.literal - acc)) else $error("literal subtract wrong");
  a_subfile_res: assert property (go && instr.op == ASX_OP_SUBTRACT_ACC_FROM_FILE |=>
    (file_wr.we ? file_wr.data : acc) == $past(file_rdata - acc))
    else $error("file subtract wrong");
  a_xorlit_carry: assert property (go && instr.op == ASX_OP_XOR_LITERAL_INTO_ACC |=>
    acc == $past(instr.literal ^ acc) && $stable(flags.carry) && $stable(flags.digit_carry))
    else $error("literal xor wrong");
  a_xorfile_flags: assert property (go && instr.op == ASX_OP_XOR_ACC_WITH_FILE |=>
    $stable(flags.carry) && flags.zero == ((file_wr.we ? file_wr.data : acc) == 8'h00))
    else $error("file xor flags wrong");
  a_swap_flags: assert property (go && is_swap |=> $stable(flags)
    && (file_wr.we ? file_wr.data : acc) == $past({file_rdata[3:0], file_rdata[7:4]}))
    else $error("swap wrong");
  a_dest_file: assert property (go && use_file && instr.dest |=> file_wr.we && $stable(acc)
    && file_wr.addr == $past(instr.addr)) else $error("file destination wrong");
  a_dest_acc: assert property (go && instr.dest == `ASX_DEST_ACC |=> !file_wr.we)
    else $error("acc destination wrote file");
  a_borrow_carry: assert property (go && is_sub |=>
    flags.carry == ($past(opnd) >= $past(acc))
    && flags.digit_carry == ($past(opnd[3:0]) >= $past(acc[3:0])))
    else $error("borrow flags wrong");
  a_idle_hold: assert property (!go ##1 ce |-> $stable(acc) && $stable(flags))
    else $error("state moved while idle");

  // ----------------------------------------
  // Further checks, some against the reference values
  // ----------------------------------------
  a_idle_run: assert property (
    idle_run_q != 4'h0 |-> acc == acc_hold_q)
    else $error("accumulator drifted while idle");

  // Reset acts even with the clock enable low, so this one is never disabled
  a_rst_clear: assert property (disable iff (1'b0)
    rst |=> acc == `ASX_ACC_RST && flags == `ASX_FLAG_RST && !file_wr.we)
    else $error("reset left state behind");

  a_sub_ref: assert property (
    go && is_sub |=> dest_now == $past(ref_sub))
    else $error("subtract differs from reference");

  a_sub_zero: assert property (
    go && is_sub |=> flags.zero == (dest_now == '0))
    else $error("subtract zero flag wrong");

  a_xor_ref: assert property (
    go && is_xor |=> dest_now == $past(ref_xor))
    else $error("xor differs from reference");

  a_xorlit_zero: assert property (
    go && instr.op == ASX_OP_XOR_LITERAL_INTO_ACC |=> flags.zero == (acc == '0))
    else $error("literal xor zero flag wrong");

  a_xorfile_dc: assert property (
    go && instr.op == ASX_OP_XOR_ACC_WITH_FILE |=> $stable(flags.digit_carry))
    else $error("file xor touched digit carry");

  a_swap_ref: assert property (
    go && is_swap |=> dest_now == $past(ref_swap))
    else $error("swap differs from reference");

  a_literal_nowr: assert property (
    go && !use_file |=> !file_wr.we)
    else $error("literal form wrote the file");

  a_borrow_ref: assert property (
    go && is_sub |=> flags.carry == $past(ref_no_borrow)
    && flags.digit_carry == $past(ref_no_dborrow))
    else $error("borrow differs from reference");

  // An empty slot must leave the accumulator and flags alone and raise no file write
  a_noop_hold: assert property (
    ce && instr_valid && instr.op == ASX_OP_NONE |=> $stable(acc) && $stable(flags)
    && !file_wr.we) else $error("empty slot changed state");

  a_ce_freeze: assert property (
    !ce |=> $stable(acc) && $stable(flags) && $stable(file_wr))
    else $error("state moved with clock enable low");

  c_sub_zero: cover property (go && is_sub ##1 flags.zero);
  c_sub_borrow: cover property (go && is_sub ##1 !flags.carry);
  c_xor_file: cover property (go && instr.op == ASX_OP_XOR_ACC_WITH_FILE && instr.dest);
  c_swap_acc: cover property (go && is_swap && !instr.dest);
  c_long_idle: cover property (idle_run_q == 4'h3);
endmodule : asx_alu

// ==== design/asx_params.svh ====
// Purpose: Constants for the subtract/xor/swap execution datapath
// Assumes: 8-bit data, 7-bit file address
// Notes: Header holds definitions only
`ifndef ASX_PARAMS_SVH
`define ASX_PARAMS_SVH
`define ASX_DATA_W 8
`define ASX_ADDR_W 7
`define ASX_NYB_W 4
`define ASX_DEST_ACC 1'b0
`define ASX_DEST_FILE 1'b1
`define ASX_ACC_RST 8'h00
`define ASX_FLAG_RST 3'h0
`endif

// ==== design/asx_pkg.sv ====
// Purpose: Types for the subtract/xor/swap execution datapath
// Assumes: Widths from asx_params.svh
// Notes: Operation codes are one-hot except ASX_OP_NONE, which is zero
`include "asx_params.svh"
package asx_pkg;
  typedef enum logic [4:0] {
    ASX_OP_NONE = 5'h00,
    ASX_OP_SUBTRACT_ACC_FROM_LITERAL = 5'h01,
    ASX_OP_SUBTRACT_ACC_FROM_FILE = 5'h02,
    ASX_OP_XOR_LITERAL_INTO_ACC = 5'h04,
    ASX_OP_XOR_ACC_WITH_FILE = 5'h08,
    ASX_OP_SWAP_FILE_NYBBLES = 5'h10
  } asx_op_t;

  typedef struct packed {
    asx_op_t op;
    logic [`ASX_DATA_W-1:0] literal;
    logic [`ASX_ADDR_W-1:0] addr;
    logic dest;
  } asx_instr_t;

  typedef struct packed {
    logic carry;
    logic digit_carry;
    logic zero;
  } asx_flags_t;

  typedef struct packed {
    logic we;
    logic [`ASX_ADDR_W-1:0] addr;
    logic [`ASX_DATA_W-1:0] data;
  } asx_fwrite_t;
endpackage : asx_pkg

// ==== verif/asx_file_model.sv ====
// Purpose: Register file on the far side of the datapath
// Assumes: Combinational read, write on the strobe edge
// Notes: A pending write is forwarded so a back-to-back read sees it
`timescale 1ns/100ps
module asx_file_model (
  input wire logic mclk,
  input wire logic [6:0] addr,
  input wire asx_pkg::asx_fwrite_t wr,
  output logic [7:0] rdata
);
  import asx_pkg::*;
  logic [7:0] mem_q [128];
  initial foreach (mem_q[i]) mem_q[i] = 8'(i * 29 + 5);
  assign rdata = (wr.we && wr.addr == addr) ? wr.data : mem_q[addr];
  // Plain always: the initial fill above also writes this array
  always @(posedge mclk) if (wr.we) mem_q[wr.addr] <= wr.data;
endmodule : asx_file_model

// ==== verif/test_alu_sub_xor_swap_ops.sv ====
// Purpose: Corner and random tests of the sub/xor/swap datapath
// Assumes: File model forwards a pending write
// Notes: Expectations come from nx(), except e_adr and the e_we clear, which step() sets
`timescale 1ns/100ps
module test_alu_sub_xor_swap_ops;
  import asx_pkg::*;
  logic mclk = 0, rst = 1, ce = 1, instr_valid = 0, e_we = 0;
  asx_instr_t instr = '0;
  logic [7:0] file_rdata, acc, e_acc = 8'h00, e_dat;
  logic [6:0] e_adr;
  asx_fwrite_t file_wr;
  asx_flags_t flags, e_fl = '0;
  logic [31:0] seed = 32'h2fad;
  int n_fail = 0, compares = 0;
  asx_alu dut_u (.mclk(mclk), .rst(rst), .ce(ce), .instr_valid(instr_valid), .instr(instr),
    .file_rdata(file_rdata), .file_wr(file_wr), .acc(acc), .flags(flags));
  asx_file_model fm_u (.mclk(mclk), .addr(instr.addr), .wr(file_wr), .rdata(file_rdata));
  always #10 mclk = ~mclk;
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Returns {we, acc, flags, data}; op bits follow the one-hot codes
  function automatic logic [19:0] nx(asx_op_t op, logic [7:0] k, f, a, logic d, asx_flags_t fl);
    logic [7:0] o, r;
    logic w;
    o = (op[0] | op[2]) ? k : f;
    w = d & (op[1] | op[3] | op[4]);
    r = o - a;
    if (op[2] | op[3]) r = o ^ a;
    if (op[4]) r = {o[3:0], o[7:4]};
    if (op[0] | op[1]) fl = '{o >= a, o[3:0] >= a[3:0], r == 8'h00};
    if (op[2] | op[3]) fl.zero = (r == 8'h00);
    return {w, (w || op == ASX_OP_NONE) ? a : r, fl, r};
  endfunction : nx
  task automatic chk(logic [19:0] got, exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic finish_test();
    $display("Compares %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test
  // Check the previous cycle, then drive one instruction
  task automatic step(int n, logic [7:0] k, logic [6:0] a, logic d, logic c, logic v);
    asx_op_t op;
    @(posedge mclk);
    #1;
    chk({acc, flags}, {e_acc, e_fl});
    chk(20'(file_wr.we), 20'(e_we));
    if (e_we) chk({5'h00, file_wr.addr, file_wr.data}, {5'h00, e_adr, e_dat});
    op = (n == 5) ? ASX_OP_NONE : asx_op_t'(5'h01 << n);
    ce = c;
    instr_valid = v;
    instr = {op, k, a, d};
    #1;
    if (c && v) {e_we, e_acc, e_fl, e_dat} = nx(op, k, file_rdata, e_acc, d, e_fl);
    else if (c) e_we = 0;
    e_adr = (c && v) ? a : e_adr;
  endtask : step
  initial
  begin
    repeat (8) @(posedge mclk);
    #1 rst = 0;
    step(5, 8'h00, 7'h00, 0, 1, 1);
    step(0, 8'h00, 7'h00, 1, 1, 1);
    step(2, 8'h01, 7'h00, 1, 1, 1);
    step(0, 8'h00, 7'h00, 0, 1, 1);
    step(4, 8'h00, 7'h7f, 1, 1, 1);
    step(1, 8'h00, 7'h7f, 1, 1, 1);
    step(3, 8'h00, 7'h7f, 0, 0, 1);
    $display("Corner test done");
    repeat (400)
    begin
      seed = lfsr(seed);
      step(int'(seed[2:0]) % 6, seed[15:8], seed[22:16], seed[3], |seed[5:4], |seed[7:6]);
    end
    $display("Random test done");
    step(5, 8'h00, 7'h00, 0, 1, 0);
    finish_test();
  end
  initial
  begin
    #(20 * 1000);
    n_fail++;
    finish_test();
  end
endmodule : test_alu_sub_xor_swap_ops
